// >>> logic/usbr_pkg.sv
// constants and types for the endpoint 0 standard request responder
// assumes one 20 MHz clock and a setup decoder that hands over whole setup packets
package usbr_pkg;
  typedef struct packed {
    logic [7:0]  reqType;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } usbr_setup_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_SHOW  = 4'b1000
  } usbr_state_t;

  typedef enum logic [1:0] {SRC_ROM = 2'h0, SRC_STR = 2'h1, SRC_REG = 2'h2} usbr_src_t;

  // ----------------------------------------------------------------
  // request encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  RT_DEV_IN   = 8'h80;
  localparam logic [7:0]  RT_IF_IN    = 8'h81;
  localparam logic [7:0]  RT_EP_IN    = 8'h82;
  localparam logic [7:0]  RT_DEV_OUT  = 8'h00;
  localparam logic [7:0]  RT_EP_OUT   = 8'h02;
  localparam logic [7:0]  RQ_STATUS   = 8'h00;
  localparam logic [7:0]  RQ_CLR_FEAT = 8'h01;
  localparam logic [7:0]  RQ_SET_FEAT = 8'h03;
  localparam logic [7:0]  RQ_GET_DESC = 8'h06;
  localparam logic [7:0]  RQ_GET_CFG  = 8'h08;
  localparam logic [7:0]  RQ_GET_IF   = 8'h0A;
  localparam logic [15:0] FEAT_WAKEUP = 16'h0001;
  localparam logic [15:0] FEAT_HALT   = 16'h0000;
  localparam logic [15:0] LANG_INDEX  = 16'h0904;
  localparam logic [7:0]  DT_DEVICE   = 8'h01;
  localparam logic [7:0]  DT_CONFIG   = 8'h02;
  localparam logic [7:0]  DT_STRING   = 8'h03;
  localparam logic [7:0]  EP_CTRL_OUT = 8'h00;
  localparam logic [7:0]  EP_CTRL_IN  = 8'h80;
  localparam logic [7:0]  EP_BULK_IN  = 8'h81;
  localparam logic [7:0]  EP_BULK_OUT = 8'h02;
  localparam logic [7:0]  EP_INTR_IN  = 8'h83;

  // ----------------------------------------------------------------
  // descriptor image layout and lengths
  // ----------------------------------------------------------------
  localparam logic [6:0] ROM_DEV_BASE  = 7'h00;
  localparam logic [6:0] ROM_CFG_BASE  = 7'h12;
  localparam logic [6:0] ROM_LANG_BASE = 7'h39;
  localparam logic [6:0] ROM_VID_LO    = 7'h08;
  localparam logic [6:0] ROM_PID_HI    = 7'h0B;
  localparam logic [6:0] ROM_MAX_PWR   = 7'h1A;
  localparam logic [6:0] ROM_POLL      = 7'h38;
  localparam logic [7:0] LEN_DEVICE    = 8'h12;
  localparam logic [7:0] LEN_CONFIG    = 8'h27;
  localparam logic [7:0] LEN_LANG      = 8'h04;
  localparam logic [7:0] LEN_STR_MAX   = 8'h20;
  localparam logic [7:0] LEN_STATUS    = 8'h02;
  localparam logic [7:0] LEN_ONE       = 8'h01;
  localparam logic [7:0] STR_SLOTS     = 8'h60;
  localparam logic [15:0] RELEASE_ID   = 16'h0210; // arbitrary value

  // ----------------------------------------------------------------
  // register port map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MAX_PWR = 8'h00;
  localparam logic [7:0] REG_POLL    = 8'h01;
  localparam logic [7:0] REG_STATUS  = 8'h02;
  localparam logic [7:0] REG_STR_BASE = 8'h80;
  localparam logic [7:0] RST_MAX_PWR = 8'h32;
  localparam logic [7:0] RST_POLL    = 8'h0A;
endpackage

// >>> logic/usbr_desc_rom.sv
// fixed descriptor image: device, configuration set and language list
// assumes the caller patches the programmable and loaded bytes
module usbr_desc_rom (
  // clock
  input  wire logic       mclk,
  // read port
  input  wire logic [5:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] romByte;

  always_comb begin
    case (rdAddr)
      6'h00: romByte = 8'h12;
      6'h01: romByte = 8'h01;
      6'h02: romByte = 8'h10;
      6'h03: romByte = 8'h01;
      6'h04: romByte = 8'hFF;
      6'h05: romByte = 8'h00;
      6'h06: romByte = 8'hFF;
      6'h07: romByte = 8'h08;
      6'h0C: romByte = usbr_pkg::RELEASE_ID[7:0];
      6'h0D: romByte = usbr_pkg::RELEASE_ID[15:8];
      6'h0E: romByte = 8'h01;
      6'h0F: romByte = 8'h02;
      6'h10: romByte = 8'h03;
      6'h11: romByte = 8'h01;
      6'h12: romByte = 8'h09;
      6'h13: romByte = 8'h02;
      6'h14: romByte = 8'h27;
      6'h16: romByte = 8'h01;
      6'h19: romByte = 8'hE0;
      // interface: one interface, three endpoints, vendor class
      6'h1B: romByte = 8'h09;
      6'h1C: romByte = 8'h04;
      6'h1F: romByte = 8'h03;
      6'h20: romByte = 8'hFF;
      6'h24: romByte = 8'h07;
      6'h25: romByte = 8'h05;
      6'h26: romByte = 8'h81;
      6'h27: romByte = 8'h02;
      6'h28: romByte = 8'h40;
      6'h2B: romByte = 8'h07;
      6'h2C: romByte = 8'h05;
      6'h2D: romByte = 8'h02;
      6'h2E: romByte = 8'h02;
      6'h2F: romByte = 8'h40;
      6'h32: romByte = 8'h07;
      6'h33: romByte = 8'h05;
      6'h34: romByte = 8'h83;
      6'h35: romByte = 8'h03;
      6'h36: romByte = 8'h08;
      6'h39: romByte = 8'h04;
      6'h3A: romByte = 8'h03;
      6'h3B: romByte = 8'h09;
      6'h3C: romByte = 8'h04;
      default: romByte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    rdData <= romByte;
  end

  a_rom_dev_head: assert property (@(posedge mclk) rdAddr == 6'h00 |=> rdData == 8'h12)
    else $error("device descriptor does not start with length 12");
endmodule

// >>> logic/usbr_str_mem.sv
// string text memory, written by software, read by the responder
// assumes one write and one read port on the same clock
module usbr_str_mem (
  // clock
  input  wire logic       mclk,
  // write port
  input  wire logic       wrEn,
  input  wire logic [6:0] wrAddr,
  input  wire logic [7:0] wrData,
  // read port
  input  wire logic [6:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] mem [0:95];

  // no reset on contents: the text is loaded by software before use
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// >>> logic/usbr_ep0_responder.sv
// answers standard control requests on endpoint 0
// assumes setup packets, token notices and bus strobes come from logic on mclk
module usbr_ep0_responder (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // setup packets
  input  wire logic                      setupValid,
  input  wire usbr_pkg::usbr_setup_t     setupPkt,
  // data stage bytes
  input  wire logic                      txReady,
  output logic                           txValid_ff,
  output logic                    [7:0]  txData_ff,
  output logic                           txLast_ff,
  // setup outcome
  output logic                           ctrlAck_ff,
  output logic                           ctrlStall_ff,
  // data tokens
  input  wire logic                      tokValid,
  input  wire logic               [1:0]  tokEp,
  output logic                           tokStall_ff,
  // identifiers from the configuration memory loader
  input  wire logic                      idLoad,
  input  wire logic               [15:0] idVendor,
  input  wire logic               [15:0] idProduct,
  // register port
  input  wire logic               [7:0]  regAddr,
  input  wire logic               [7:0]  regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic                    [7:0]  regRdata_ff
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  usbr_pkg::usbr_state_t state_ff;
  usbr_pkg::usbr_src_t   src_ff;
  logic [6:0]  base_ff;
  logic [7:0]  idx_ff;
  logic [7:0]  txLen_ff;
  logic [15:0] regVal_ff;
  logic [3:0]  stall_ff;
  logic        wakeup_ff;
  logic        idLoaded_ff;
  logic [15:0] vid_ff;
  logic [15:0] pid_ff;
  logic [7:0]  maxPwr_ff;
  logic [7:0]  intrPollPeriodSetting_ff;
  logic [7:0]  strLen_ff [0:2];
  logic [7:0]  romData;
  logic [7:0]  strData;

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // setup decode
  // ----------------------------------------------------------------
  wire [7:0] rt      = setupPkt.reqType;
  wire [7:0] rq      = setupPkt.request;
  wire [7:0] dType   = setupPkt.value[15:8];
  wire [7:0] dIdx    = setupPkt.value[7:0];
  wire [7:0] epIdx   = setupPkt.index[7:0];
  wire [1:0] epNum   = setupPkt.index[1:0];
  wire       epKnown = epIdx == usbr_pkg::EP_CTRL_OUT || epIdx == usbr_pkg::EP_CTRL_IN
                    || epIdx == usbr_pkg::EP_BULK_IN || epIdx == usbr_pkg::EP_BULK_OUT
                    || epIdx == usbr_pkg::EP_INTR_IN;
  wire isDevStat = rt == usbr_pkg::RT_DEV_IN && rq == usbr_pkg::RQ_STATUS;
  wire isIfStat  = rt == usbr_pkg::RT_IF_IN && rq == usbr_pkg::RQ_STATUS;
  wire isEpStat  = rt == usbr_pkg::RT_EP_IN && rq == usbr_pkg::RQ_STATUS && epKnown;
  wire isGetDesc = rt == usbr_pkg::RT_DEV_IN && rq == usbr_pkg::RQ_GET_DESC;
  wire isDevDesc = isGetDesc && dType == usbr_pkg::DT_DEVICE;
  wire isCfgDesc = isGetDesc && dType == usbr_pkg::DT_CONFIG;
  wire isLang    = isGetDesc && dType == usbr_pkg::DT_STRING && dIdx == 8'h00;
  wire isStr     = isGetDesc && dType == usbr_pkg::DT_STRING && dIdx >= 8'h01 && dIdx <= 8'h03
                && setupPkt.index == usbr_pkg::LANG_INDEX;
  wire isGetCfg  = rt == usbr_pkg::RT_DEV_IN && rq == usbr_pkg::RQ_GET_CFG;
  wire isGetIf   = rt == usbr_pkg::RT_IF_IN && rq == usbr_pkg::RQ_GET_IF;
  wire isWakeClr = rt == usbr_pkg::RT_DEV_OUT && rq == usbr_pkg::RQ_CLR_FEAT
                && setupPkt.value == usbr_pkg::FEAT_WAKEUP;
  wire isWakeSet = rt == usbr_pkg::RT_DEV_OUT && rq == usbr_pkg::RQ_SET_FEAT
                && setupPkt.value == usbr_pkg::FEAT_WAKEUP;
  wire isHaltClr = rt == usbr_pkg::RT_EP_OUT && rq == usbr_pkg::RQ_CLR_FEAT
                && setupPkt.value == usbr_pkg::FEAT_HALT;
  wire isHaltSet = rt == usbr_pkg::RT_EP_OUT && rq == usbr_pkg::RQ_SET_FEAT
                && setupPkt.value == usbr_pkg::FEAT_HALT;
  wire isRegSrc  = isDevStat || isIfStat || isEpStat || isGetCfg || isGetIf;
  wire isIn      = isRegSrc || isDevDesc || isCfgDesc || isLang || isStr;
  wire isNoData  = isWakeClr || isWakeSet || isHaltClr || isHaltSet;
  wire [1:0] strSlot = dIdx[1:0] - 2'd1;

  // ----------------------------------------------------------------
  // answer length and source
  // ----------------------------------------------------------------
  wire [7:0] natLen = isDevDesc ? usbr_pkg::LEN_DEVICE :
                      isCfgDesc ? usbr_pkg::LEN_CONFIG :
                      isLang    ? usbr_pkg::LEN_LANG :
                      isStr     ? strLen_ff[strSlot] :
                      (isGetCfg || isGetIf) ? usbr_pkg::LEN_ONE :
                      usbr_pkg::LEN_STATUS;
  // lengths above 255 saturate: no answer here is that long
  wire [7:0] reqLen = (setupPkt.length[15:8] != 8'h00) ? 8'hFF : setupPkt.length[7:0];
  wire [7:0] nxt_txLen = min8(natLen, reqLen);
  wire usbr_pkg::usbr_src_t nxt_src = isStr ? usbr_pkg::SRC_STR :
                                      isRegSrc ? usbr_pkg::SRC_REG : usbr_pkg::SRC_ROM;
  wire [6:0] nxt_base = isStr ? {strSlot, 5'h00} :
                        isCfgDesc ? usbr_pkg::ROM_CFG_BASE :
                        isLang ? usbr_pkg::ROM_LANG_BASE : usbr_pkg::ROM_DEV_BASE;
  wire [15:0] nxt_regVal = isDevStat ? {14'h0000, wakeup_ff, 1'b1} :
                           isEpStat ? {15'h0000, stall_ff[epNum]} :
                           16'h0000;
  wire setupTake = setupValid && state_ff == usbr_pkg::ST_IDLE;

  // ----------------------------------------------------------------
  // byte assembly
  // ----------------------------------------------------------------
  wire [6:0] memAddr = base_ff + idx_ff[6:0];
  wire [6:0] romPos  = memAddr;
  wire [7:0] romPatched =
      (romPos == usbr_pkg::ROM_VID_LO)        ? vid_ff[7:0]  :
      (romPos == usbr_pkg::ROM_VID_LO + 7'd1) ? vid_ff[15:8] :
      (romPos == usbr_pkg::ROM_PID_HI - 7'd1) ? pid_ff[7:0]  :
      (romPos == usbr_pkg::ROM_PID_HI)        ? pid_ff[15:8] :
      (romPos == usbr_pkg::ROM_MAX_PWR)       ? maxPwr_ff :
      (romPos == usbr_pkg::ROM_POLL)          ? intrPollPeriodSetting_ff : romData;
  wire [7:0] strByte = (idx_ff == 8'h00) ? txLen_ff :
                       (idx_ff == 8'h01) ? usbr_pkg::DT_STRING : strData;
  wire [7:0] strLenHdr = strLen_ff[base_ff[6:5]];
  wire [7:0] strFirst  = (idx_ff == 8'h00) ? strLenHdr : strByte;
  wire [7:0] nxt_byte = (src_ff == usbr_pkg::SRC_STR) ? strFirst :
                        (src_ff == usbr_pkg::SRC_REG) ? (idx_ff[0] ? regVal_ff[15:8] : regVal_ff[7:0]) :
                        romPatched;
  wire lastByte = idx_ff == txLen_ff - 8'd1;
  wire byteTaken = state_ff == usbr_pkg::ST_SHOW && txReady;

  usbr_desc_rom u_rom (
    .mclk   (mclk),
    .rdAddr (memAddr[5:0]),
    .rdData (romData)
  );

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire strWr = regWr && regAddr[7] && regAddr[6:0] < usbr_pkg::STR_SLOTS[6:0];
  wire strHdrWr = strWr && regAddr[4:0] == 5'h00;
  wire [7:0] hdrLen = min8(regWdata, usbr_pkg::LEN_STR_MAX);
  wire [7:0] nxt_rdata = (regAddr == usbr_pkg::REG_MAX_PWR) ? maxPwr_ff :
                         (regAddr == usbr_pkg::REG_POLL) ? intrPollPeriodSetting_ff :
                         (regAddr == usbr_pkg::REG_STATUS) ? {2'b00, idLoaded_ff, wakeup_ff, stall_ff} :
                         8'h00;

  usbr_str_mem u_str (
    .mclk   (mclk),
    .wrEn   (strWr),
    .wrAddr (regAddr[6:0]),
    .wrData (regWdata),
    .rdAddr (memAddr),
    .rdData (strData)
  );

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff     <= usbr_pkg::ST_IDLE;
      src_ff       <= usbr_pkg::SRC_ROM;
      base_ff      <= 7'h00;
      idx_ff       <= 8'h00;
      txLen_ff     <= 8'h00;
      regVal_ff    <= 16'h0000;
      txValid_ff   <= 1'b0;
      txData_ff    <= 8'h00;
      txLast_ff    <= 1'b0;
      ctrlAck_ff   <= 1'b0;
      ctrlStall_ff <= 1'b0;
    end else begin
      ctrlAck_ff   <= setupTake && (isNoData || (isIn && nxt_txLen == 8'h00));
      ctrlStall_ff <= setupTake && !isNoData && !isIn;
      case (state_ff)
        usbr_pkg::ST_IDLE: begin
          if (setupTake && isIn && nxt_txLen != 8'h00) begin
            src_ff    <= nxt_src;
            base_ff   <= nxt_base;
            idx_ff    <= 8'h00;
            txLen_ff  <= nxt_txLen;
            regVal_ff <= nxt_regVal;
            state_ff  <= usbr_pkg::ST_FETCH;
          end
        end
        usbr_pkg::ST_FETCH: begin
          state_ff <= usbr_pkg::ST_LOAD;
        end
        usbr_pkg::ST_LOAD: begin
          txData_ff  <= nxt_byte;
          txLast_ff  <= lastByte;
          txValid_ff <= 1'b1;
          state_ff   <= usbr_pkg::ST_SHOW;
        end
        usbr_pkg::ST_SHOW: begin
          if (txReady) begin
            txValid_ff <= 1'b0;
            txLast_ff  <= 1'b0;
            idx_ff     <= idx_ff + 8'd1;
            state_ff   <= lastByte ? usbr_pkg::ST_IDLE : usbr_pkg::ST_FETCH;
          end
        end
        default: state_ff <= usbr_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // feature flags, identifiers, settings
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stall_ff    <= 4'h0;
      wakeup_ff   <= 1'b0;
      tokStall_ff <= 1'b0;
      idLoaded_ff <= 1'b0;
      vid_ff      <= 16'h0000;
      pid_ff      <= 16'h0000;
    end else begin
      if (setupTake && isHaltSet) begin
        stall_ff[epNum] <= 1'b1;
      end else if (setupTake && isHaltClr) begin
        stall_ff[epNum] <= 1'b0;
      end
      if (setupTake && isWakeSet) begin
        wakeup_ff <= 1'b1;
      end else if (setupTake && isWakeClr) begin
        wakeup_ff <= 1'b0;
      end
      tokStall_ff <= tokValid && stall_ff[tokEp];
      if (idLoad) begin
        vid_ff      <= idVendor;
        pid_ff      <= idProduct;
        idLoaded_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      maxPwr_ff                <= usbr_pkg::RST_MAX_PWR;
      intrPollPeriodSetting_ff <= usbr_pkg::RST_POLL;
      regRdata_ff              <= 8'h00;
      strLen_ff[0]             <= 8'h00;
      strLen_ff[1]             <= 8'h00;
      strLen_ff[2]             <= 8'h00;
    end else begin
      regRdata_ff <= regRd ? nxt_rdata : 8'h00;
      if (regWr && regAddr == usbr_pkg::REG_MAX_PWR) begin
        maxPwr_ff <= regWdata;
      end
      if (regWr && regAddr == usbr_pkg::REG_POLL) begin
        intrPollPeriodSetting_ff <= regWdata;
      end
      // a string slot's first byte holds its descriptor length
      if (strHdrWr) begin
        strLen_ff[regAddr[6:5]] <= hdrLen;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_halt_set_flag: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isHaltSet |=> stall_ff[$past(epNum)])
    else $error("endpoint stall flag not set");
  a_halt_clr_flag: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isHaltClr |=> !stall_ff[$past(epNum)])
    else $error("endpoint stall flag not cleared");
  a_wake_set_flag: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isWakeSet |=> wakeup_ff && ctrlAck_ff)
    else $error("remote wakeup not set and acknowledged");
  a_wake_clr_flag: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isWakeClr |=> !wakeup_ff)
    else $error("remote wakeup not cleared");
  a_dev_desc_len: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isDevDesc && setupPkt.length >= 16'h0012 |=> txLen_ff == 8'h12)
    else $error("device descriptor length wrong");
  a_cfg_desc_len: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isCfgDesc |=> txLen_ff <= 8'h27 && txLen_ff <= $past(reqLen))
    else $error("configuration answer too long");
  a_tok_stall_ans: assert property (@(posedge mclk) disable iff (!resetn)
    tokValid && stall_ff[tokEp] |=> tokStall_ff)
    else $error("stalled endpoint token not answered with stall");
  a_status_first: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isEpStat && nxt_txLen != 8'h00 |-> ##3 txValid_ff && txData_ff == {7'h00, stall_ff[epNum]})
    else $error("endpoint status byte wrong");
  a_iface_zero: assert property (@(posedge mclk) disable iff (!resetn)
    setupTake && isGetIf && setupPkt.length != 16'h0000 |-> ##3 txValid_ff && txData_ff == 8'h00 && txLast_ff)
    else $error("alternate setting byte wrong");
endmodule

// >>> testbench/usbr_host_model.sv
// host side model: takes data stage bytes, promptly or slowly
// assumes the responder's byte handshake on mclk
module usbr_host_model (
  // clock and pacing
  input  wire logic       mclk,
  input  wire logic       slow,
  // data stage
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output logic            txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         lastLen;
  initial txReady = 1'b0;
  // slow mode takes on every other edge, so each byte must stand
  always @(posedge mclk) begin
    if (txValid && txReady) begin
      got.push_back(txData);
      if (txLast) lastLen = got.size();
    end
    txReady <= slow ? ~txReady : 1'b1;
  end
endmodule

// >>> testbench/tb_usbr_ep0_responder.sv
// bench for the endpoint 0 responder: setups, tokens and register port
// assumes the host model stands on the data stage
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_usbr_ep0_responder;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, resetn = 1'b0, slow = 1'b0, setupValid = 1'b0, tokValid = 1'b0;
  logic idLoad = 1'b0, regWr = 1'b0, regRd = 1'b0, txReady, txValid, txLast, ack, stl, tokStall;
  logic [1:0] tokEp = 2'h0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, txData, regRdata;
  logic [15:0] idVendor = 16'h1234, idProduct = 16'h5678;
  usbr_pkg::usbr_setup_t setupPkt = '0;
  logic [7:0] e[$];
  int n_errors = 0, checks = 0;
  always #25 mclk = ~mclk;
  usbr_ep0_responder uut (.mclk(mclk), .resetn(resetn), .setupValid(setupValid), .setupPkt(setupPkt),
    .txReady(txReady), .txValid_ff(txValid), .txData_ff(txData), .txLast_ff(txLast), .ctrlAck_ff(ack),
    .ctrlStall_ff(stl), .tokValid(tokValid), .tokEp(tokEp), .tokStall_ff(tokStall), .idLoad(idLoad),
    .idVendor(idVendor), .idProduct(idProduct), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata_ff(regRdata));
  usbr_host_model hm (.mclk(mclk), .slow(slow), .txValid(txValid), .txData(txData), .txLast(txLast),
    .txReady(txReady));
  task automatic final_report();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) begin regAddr <= a; regWdata <= d; regWr <= 1'b1; end
    @(posedge mclk) regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge mclk) regRd <= 1'b0;
    @(posedge mclk) `CHK(regRdata, x)
  endtask
  // sends one setup, checks its outcome pulses and every data byte in e
  task automatic xfer(input logic [7:0] rt, rq, input logic [15:0] v, i, l, input logic a, s);
    hm.got.delete();
    hm.lastLen = 0;
    @(posedge mclk) begin setupPkt <= '{rt, rq, v, i, l}; setupValid <= 1'b1; end
    @(posedge mclk) setupValid <= 1'b0;
    @(posedge mclk) begin `CHK(ack, a) `CHK(stl, s) end
    for (int k = 0; k < 600 && hm.got.size() < e.size(); k++) @(posedge mclk);
    repeat (10) @(posedge mclk);
    `CHK(hm.got.size(), e.size())
    if (e.size() > 0) `CHK(hm.lastLen, e.size())
    for (int k = 0; k < e.size() && k < hm.got.size(); k++) `CHK(hm.got[k], e[k])
  endtask
  task automatic tok(input logic [1:0] ep, input logic x);
    @(posedge mclk) begin tokEp <= ep; tokValid <= 1'b1; end
    @(posedge mclk) tokValid <= 1'b0;
    @(posedge mclk) `CHK(tokStall, x)
  endtask
  initial begin
    // every scenario together takes well under this span; a hang ends here
    #(20000 * 50);
    n_errors++;
    final_report();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h00, 8'h32); rd(8'h01, 8'h0A); rd(8'h02, 8'h00); rd(8'h40, 8'h00);
    wr(8'h00, 8'h55); wr(8'h01, 8'h07); wr(8'h02, 8'hFF); rd(8'h02, 8'h00);
    @(posedge mclk) idLoad <= 1'b1;
    @(posedge mclk) idLoad <= 1'b0;
    e = '{8'h12, 8'h01, 8'h10, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h08, 8'h34, 8'h12, 8'h78, 8'h56,
      usbr_pkg::RELEASE_ID[7:0], usbr_pkg::RELEASE_ID[15:8], 8'h01, 8'h02, 8'h03, 8'h01};
    xfer(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0040, 1'b0, 1'b0);
    e = e[0:7];
    xfer(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0008, 1'b0, 1'b0);
    slow <= 1'b1;
    e = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h00, 8'h00, 8'hE0, 8'h55, 8'h09, 8'h04, 8'h00, 8'h00,
      8'h03, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h07, 8'h05, 8'h81, 8'h02, 8'h40, 8'h00, 8'h00, 8'h07,
      8'h05, 8'h02, 8'h02, 8'h40, 8'h00, 8'h00, 8'h07, 8'h05, 8'h83, 8'h03, 8'h08, 8'h00, 8'h07};
    xfer(8'h80, 8'h06, 16'h0200, 16'h0000, 16'h00FF, 1'b0, 1'b0);
    e = e[0:9];
    xfer(8'h80, 8'h06, 16'h0200, 16'h0000, 16'h000A, 1'b0, 1'b0);
    slow <= 1'b0;
    e = '{8'h04, 8'h03, 8'h09, 8'h04};
    xfer(8'h80, 8'h06, 16'h0300, 16'h0000, 16'h00FF, 1'b0, 1'b0);
    wr(8'h80, 8'h04); wr(8'h82, 8'h41); wr(8'h83, 8'h42);
    e = '{8'h04, 8'h03, 8'h41, 8'h42};
    xfer(8'h80, 8'h06, 16'h0301, 16'h0904, 16'h00FF, 1'b0, 1'b0);
    e = {};
    xfer(8'h80, 8'h06, 16'h0301, 16'h0409, 16'h00FF, 1'b0, 1'b1);
    e = '{8'h00};
    xfer(8'h81, 8'h0A, 16'h0000, 16'h0000, 16'h0001, 1'b0, 1'b0);
    xfer(8'h80, 8'h08, 16'h0000, 16'h0000, 16'h0001, 1'b0, 1'b0);
    e = {};
    xfer(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0000, 1'b1, 1'b0);
    xfer(8'h00, 8'h03, 16'h0001, 16'h0000, 16'h0000, 1'b1, 1'b0);
    rd(8'h02, 8'h30);
    e = '{8'h03, 8'h00};
    xfer(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 1'b0, 1'b0);
    e = {};
    xfer(8'h00, 8'h01, 16'h0001, 16'h0000, 16'h0000, 1'b1, 1'b0);
    e = '{8'h01, 8'h00};
    xfer(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 1'b0, 1'b0);
    for (int n = 0; n < 4; n++) begin
      e = {};
      xfer(8'h02, 8'h03, 16'h0000, 16'(n), 16'h0000, 1'b1, 1'b0);
      tok(2'(n), 1'b1);
      e = '{8'h01, 8'h00};
      xfer(8'h82, 8'h00, 16'h0000, 16'(n == 2 ? 2 : 8'h80 | n), 16'h0002, 1'b0, 1'b0);
    end
    e = {};
    xfer(8'h02, 8'h01, 16'h0000, 16'h0002, 16'h0000, 1'b1, 1'b0);
    tok(2'h2, 1'b0);
    rd(8'h02, 8'h2B);
    e = '{8'h00, 8'h00};
    xfer(8'h82, 8'h00, 16'h0000, 16'h0002, 16'h0002, 1'b0, 1'b0);
    final_report();
  end
endmodule
